// *** pkg/tmcf_pkg.sv ***
// constants, codes and register map of the test mode contact forcing block
`default_nettype none

package tmcf_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_FIN  = 8;
  localparam int unsigned NUM_FOUT = 8;
  localparam int unsigned NUM_TRIG = 32;
  localparam int unsigned NUM_REM  = 32;
  localparam int unsigned NUM_SIN  = 32;
  localparam int unsigned NUM_SOUT = 64;
  localparam int unsigned SEL_W    = 5;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned SYNC_W   = 24;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_IN_FORCE  = 8'h08;
  localparam logic [7:0] REG_OUT_FORCE = 8'h0C;
  localparam logic [7:0] REG_IN_STATE  = 8'h10;
  localparam logic [7:0] REG_OUT_STATE = 8'h14;
  localparam logic [7:0] REG_REM_DEF   = 8'h18;
  localparam logic [7:0] REG_REM_STATE = 8'h1C;
  localparam logic [7:0] REG_SOFT_IN   = 8'h20;
  localparam logic [7:0] REG_SOFT_OLO  = 8'h24;
  localparam logic [7:0] REG_SOFT_OHI  = 8'h28;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_CONST_BIT = 1;
  localparam int unsigned CTRL_SEL_LSB   = 8;
  localparam int unsigned STAT_ACT_BIT   = 0;
  localparam int unsigned OST_DRV_LSB    = 0;
  localparam int unsigned OST_VDET_LSB   = 8;
  localparam int unsigned OST_IDET_LSB   = 16;
  localparam int unsigned MODE_TEST_BIT  = 1;

  localparam logic             CTRL_EN_RST    = 1'b0;
  localparam logic             CTRL_CONST_RST = 1'b1;
  localparam logic [SEL_W-1:0] CTRL_SEL_RST   = 5'h00;
  localparam logic [15:0]      FORCE_RST      = 16'h0000;
  localparam logic [31:0]      REM_DEF_RST    = 32'h00000000;
  localparam logic [7:0]       FORM_A_MASK    = 8'h0F;

  // ----------------------------------------------------------------
  // force codes
  // ----------------------------------------------------------------
  localparam logic [1:0] IN_FORCE_OFF     = 2'h0;
  localparam logic [1:0] IN_FORCE_OPEN    = 2'h1;
  localparam logic [1:0] IN_FORCE_CLOSED  = 2'h2;
  localparam logic [1:0] OUT_FORCE_OFF    = 2'h0;
  localparam logic [1:0] OUT_FORCE_ENERG  = 2'h1;
  localparam logic [1:0] OUT_FORCE_DEENRG = 2'h2;
  localparam logic [1:0] OUT_FORCE_FREEZE = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned FLASH_HALF_MS  = 250;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_CNT_W    = 25;

  // ----------------------------------------------------------------
  // test mode states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TMCF_IDLE = 2'b01,
    TMCF_TEST = 2'b10
  } tmcf_mode_e;

endpackage

`default_nettype wire

// *** hw/tmcf_flash.sv ***
// flashing pattern generator for the test indicator
`default_nettype none

module tmcf_flash #(
  parameter int unsigned HALF_CYC = tmcf_pkg::FLASH_HALF_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output var  logic lamp
);

  typedef struct packed {
    logic [tmcf_pkg::FLASH_CNT_W-1:0] cnt;
    logic                             lamp;
  } tmcf_flash_s;

  localparam logic [tmcf_pkg::FLASH_CNT_W-1:0] LAST =
    tmcf_pkg::FLASH_CNT_W'(HALF_CYC - 1);

  tmcf_flash_s r;
  tmcf_flash_s n;

  // ----------------------------------------------------------------
  // lamp toggles every half period, lit one cycle after run rises
  // ----------------------------------------------------------------
  always_comb
  begin
    n = r;
    if (!run)
    begin
      n.cnt  = '0;
      n.lamp = 1'b0;
    end
    else if (r.cnt == '0)
    begin
      n.cnt  = LAST;
      n.lamp = ~r.lamp;
    end
    else
    begin
      n.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= n;
  end

  assign lamp = r.lamp;

endmodule

`default_nettype wire

// *** hw/tmcf_top.sv ***
// test mode controller with contact input and output forcing, apb registers
`default_nettype none

// Notes on behaviour
// - test mode only while enable is set and selected trigger is one
// - constant-on trigger starts test mode when enable goes from off to on
// - operand trigger, enable set, starts test mode when operand becomes one
// - test indicator flashes while test mode is active
// - all other logic runs normally; only contacts change behaviour
// - every field input and output has its own independent force setting
// - input with force off follows its sensed terminal during test mode
// - input forced open reports zero for the whole test mode
// - input forced closed reports one for the whole test mode
// - with all input forces off, inputs behave as in normal operation
// - output with force off follows its command: one operates, zero resets
// - energized output is driven closed for the whole test mode
// - de-energized output is driven open for the whole test mode
// - frozen output holds the state it had just before test mode
// - reported status uses one for on and zero for off
// - remote inputs report point state, or programmed default when offline
// - form-C outputs report only on/off; form-A adds detector states
// - report the 64 soft outputs as their equations give them
// - report the 32 soft inputs
module tmcf_top #(
  parameter int unsigned FLASH_HALF_CYC = tmcf_pkg::FLASH_HALF_CYC
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic [tmcf_pkg::ADDR_W-1:0]    paddr,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [31:0]                    pwdata,
  input  wire logic [3:0]                     pstrb,
  output var  logic                           pready,
  output var  logic [31:0]                    prdata,
  output var  logic                           pslverr,
  input  wire logic [tmcf_pkg::NUM_FIN-1:0]   field_input_pin,
  input  wire logic [tmcf_pkg::NUM_FOUT-1:0]  volt_det_pin,
  input  wire logic [tmcf_pkg::NUM_FOUT-1:0]  curr_det_pin,
  input  wire logic [tmcf_pkg::NUM_TRIG-1:0]  trig_operand,
  input  wire logic [tmcf_pkg::NUM_FOUT-1:0]  out_command,
  input  wire logic [tmcf_pkg::NUM_REM-1:0]   remote_point,
  input  wire logic [tmcf_pkg::NUM_REM-1:0]   remote_online,
  input  wire logic [tmcf_pkg::NUM_SIN-1:0]   soft_input,
  input  wire logic [tmcf_pkg::NUM_SOUT-1:0]  soft_output,
  output var  logic [tmcf_pkg::NUM_FIN-1:0]   field_input_state,
  output var  logic [tmcf_pkg::NUM_FOUT-1:0]  field_output_drive,
  output var  logic                           test_active,
  output var  logic                           test_indicator
);

  typedef struct packed {
    tmcf_pkg::tmcf_mode_e             mode;
    logic                             ctrl_en;
    logic                             ctrl_const;
    logic [tmcf_pkg::SEL_W-1:0]       ctrl_sel;
    logic [15:0]                      in_force;
    logic [15:0]                      out_force;
    logic [31:0]                      rem_def;
    logic [tmcf_pkg::SYNC_W-1:0]      sync1;
    logic [tmcf_pkg::SYNC_W-1:0]      sync2;
    logic [tmcf_pkg::SYNC_W-1:0]      sync3;
    logic [tmcf_pkg::SYNC_W-1:0]      filt;
    logic [tmcf_pkg::NUM_FIN-1:0]     in_rep;
    logic [tmcf_pkg::NUM_FOUT-1:0]    out_drv;
    logic [tmcf_pkg::NUM_FOUT-1:0]    frozen;
    logic [31:0]                      prdata;
    logic                             pready;
    logic                             pslverr;
  } tmcf_top_s;

  tmcf_top_s r;
  tmcf_top_s n;

  logic                          trig;
  logic [tmcf_pkg::NUM_REM-1:0]  rem_state;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] field2(input logic [15:0] v, input int unsigned i);
    field2 = v[2*i +: 2];
  endfunction

  function automatic logic in_force_apply(input logic act, input logic [1:0] code,
                                          input logic sensed);
    in_force_apply = sensed;
    if (act && code == tmcf_pkg::IN_FORCE_OPEN)
      in_force_apply = 1'b0;
    else if (act && code == tmcf_pkg::IN_FORCE_CLOSED)
      in_force_apply = 1'b1;
  endfunction

  function automatic logic out_force_apply(input logic act, input logic [1:0] code,
                                           input logic cmd, input logic held);
    out_force_apply = cmd;
    if (act)
    begin
      unique case (code)
        tmcf_pkg::OUT_FORCE_OFF:    out_force_apply = cmd;
        tmcf_pkg::OUT_FORCE_ENERG:  out_force_apply = 1'b1;
        tmcf_pkg::OUT_FORCE_DEENRG: out_force_apply = 1'b0;
        tmcf_pkg::OUT_FORCE_FREEZE: out_force_apply = held;
      endcase
    end
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    merge_strb = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        merge_strb[8*b +: 8] = wd[8*b +: 8];
    end
  endfunction

  function automatic logic reg_mapped(input logic [tmcf_pkg::ADDR_W-1:0] a);
    reg_mapped = (a == tmcf_pkg::REG_CTRL)      || (a == tmcf_pkg::REG_STATUS)   ||
                 (a == tmcf_pkg::REG_IN_FORCE)  || (a == tmcf_pkg::REG_OUT_FORCE) ||
                 (a == tmcf_pkg::REG_IN_STATE)  || (a == tmcf_pkg::REG_OUT_STATE) ||
                 (a == tmcf_pkg::REG_REM_DEF)   || (a == tmcf_pkg::REG_REM_STATE) ||
                 (a == tmcf_pkg::REG_SOFT_IN)   || (a == tmcf_pkg::REG_SOFT_OLO)  ||
                 (a == tmcf_pkg::REG_SOFT_OHI);
  endfunction

  // ----------------------------------------------------------------
  // trigger and remote input resolution
  // ----------------------------------------------------------------
  assign trig      = r.ctrl_const ? 1'b1 : trig_operand[r.ctrl_sel];
  assign rem_state = (remote_online & remote_point) | (~remote_online & r.rem_def);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic        go;
    logic        act_n;
    logic        entering;
    logic [7:0]  hold;
    logic [31:0] rd;
    logic [31:0] wv;
    go       = 1'b0;
    act_n    = 1'b0;
    entering = 1'b0;
    hold     = '0;
    rd       = '0;
    wv       = '0;
    n        = r;

    // test mode sequencing
    go = r.ctrl_en & trig;
    unique case (r.mode)
      tmcf_pkg::TMCF_IDLE:
      begin
        if (go)
          n.mode = tmcf_pkg::TMCF_TEST;
      end
      tmcf_pkg::TMCF_TEST:
      begin
        if (!go)
          n.mode = tmcf_pkg::TMCF_IDLE;
      end
      default: n.mode = tmcf_pkg::TMCF_IDLE;
    endcase
    act_n    = (n.mode == tmcf_pkg::TMCF_TEST);
    entering = act_n && (r.mode != tmcf_pkg::TMCF_TEST);

    // pin synchroniser and agreement filter
    n.sync1 = {curr_det_pin, volt_det_pin, field_input_pin};
    n.sync2 = r.sync1;
    n.sync3 = r.sync2;
    for (int i = 0; i < tmcf_pkg::SYNC_W; i++)
    begin
      if (r.sync2[i] == r.sync3[i])
        n.filt[i] = r.sync3[i];
    end

    // contact inputs
    for (int i = 0; i < tmcf_pkg::NUM_FIN; i++)
    begin
      n.in_rep[i] = in_force_apply(act_n, field2(r.in_force, i), r.filt[i]);
    end

    // contact outputs, freeze captured on entry
    hold = entering ? r.out_drv : r.frozen;
    if (entering)
      n.frozen = r.out_drv;
    for (int i = 0; i < tmcf_pkg::NUM_FOUT; i++)
    begin
      n.out_drv[i] = out_force_apply(act_n, field2(r.out_force, i), out_command[i],
                                     hold[i]);
    end

    // apb: data prepared in setup, presented in the access cycle
    n.pready  = psel && !penable;
    n.prdata  = '0;
    n.pslverr = 1'b0;
    if (psel && !penable)
    begin
      n.pslverr = !reg_mapped(paddr);
      unique case (paddr)
        tmcf_pkg::REG_CTRL:
        begin
          rd[tmcf_pkg::CTRL_EN_BIT]                         = r.ctrl_en;
          rd[tmcf_pkg::CTRL_CONST_BIT]                      = r.ctrl_const;
          rd[tmcf_pkg::CTRL_SEL_LSB +: tmcf_pkg::SEL_W]     = r.ctrl_sel;
        end
        tmcf_pkg::REG_STATUS:    rd[tmcf_pkg::STAT_ACT_BIT] = r.mode[tmcf_pkg::MODE_TEST_BIT];
        tmcf_pkg::REG_IN_FORCE:  rd[15:0] = r.in_force;
        tmcf_pkg::REG_OUT_FORCE: rd[15:0] = r.out_force;
        tmcf_pkg::REG_IN_STATE:  rd[7:0]  = r.in_rep;
        tmcf_pkg::REG_OUT_STATE:
        begin
          rd[tmcf_pkg::OST_DRV_LSB +: 8]  = r.out_drv;
          rd[tmcf_pkg::OST_VDET_LSB +: 8] = r.filt[15:8] & tmcf_pkg::FORM_A_MASK;
          rd[tmcf_pkg::OST_IDET_LSB +: 8] = r.filt[23:16] & tmcf_pkg::FORM_A_MASK;
        end
        tmcf_pkg::REG_REM_DEF:   rd = r.rem_def;
        tmcf_pkg::REG_REM_STATE: rd = rem_state;
        tmcf_pkg::REG_SOFT_IN:   rd = soft_input;
        tmcf_pkg::REG_SOFT_OLO:  rd = soft_output[31:0];
        tmcf_pkg::REG_SOFT_OHI:  rd = soft_output[63:32];
        default:                 rd = '0;
      endcase
      n.prdata = rd;
    end

    // writes take effect at the completing access edge
    if (psel && penable && r.pready && pwrite)
    begin
      unique case (paddr)
        tmcf_pkg::REG_CTRL:
        begin
          wv = merge_strb({16'h0000, 3'h0, r.ctrl_sel, 6'h00, r.ctrl_const, r.ctrl_en},
                          pwdata, pstrb);
          n.ctrl_en    = wv[tmcf_pkg::CTRL_EN_BIT];
          n.ctrl_const = wv[tmcf_pkg::CTRL_CONST_BIT];
          n.ctrl_sel   = wv[tmcf_pkg::CTRL_SEL_LSB +: tmcf_pkg::SEL_W];
        end
        tmcf_pkg::REG_IN_FORCE:
        begin
          wv         = merge_strb({16'h0000, r.in_force}, pwdata, pstrb);
          n.in_force = wv[15:0];
        end
        tmcf_pkg::REG_OUT_FORCE:
        begin
          wv          = merge_strb({16'h0000, r.out_force}, pwdata, pstrb);
          n.out_force = wv[15:0];
        end
        tmcf_pkg::REG_REM_DEF:   n.rem_def = merge_strb(r.rem_def, pwdata, pstrb);
        default:                 n.rem_def = r.rem_def;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r            <= '0;
      r.mode       <= tmcf_pkg::TMCF_IDLE;
      r.ctrl_en    <= tmcf_pkg::CTRL_EN_RST;
      r.ctrl_const <= tmcf_pkg::CTRL_CONST_RST;
      r.ctrl_sel   <= tmcf_pkg::CTRL_SEL_RST;
      r.in_force   <= tmcf_pkg::FORCE_RST;
      r.out_force  <= tmcf_pkg::FORCE_RST;
      r.rem_def    <= tmcf_pkg::REM_DEF_RST;
    end
    else
    begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // indicator
  // ----------------------------------------------------------------
  tmcf_flash #(
    .HALF_CYC (FLASH_HALF_CYC)
  ) u_flash (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (r.mode[tmcf_pkg::MODE_TEST_BIT]),
    .lamp    (test_indicator)
  );

  // ----------------------------------------------------------------
  // outputs; soft paths are untouched by test mode
  // ----------------------------------------------------------------
  assign pready             = r.pready;
  assign prdata             = r.prdata;
  assign pslverr            = r.pslverr;
  assign field_input_state  = r.in_rep;
  assign field_output_drive = r.out_drv;
  assign test_active        = r.mode[tmcf_pkg::MODE_TEST_BIT];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic is_act;
  assign is_act = (r.mode == tmcf_pkg::TMCF_TEST);

  sequence s_enter;
    !is_act ##1 is_act;
  endsequence

  sequence s_en_rise_const;
    !r.ctrl_en ##1 (r.ctrl_en && r.ctrl_const);
  endsequence

  a_arm_needs_both:
    assert property (is_act |-> $past(r.ctrl_en && trig))
    else $error("test mode active without enable and trigger");

  a_const_start:
    assert property (s_en_rise_const |=> is_act)
    else $error("constant trigger did not start test mode");

  a_operand_start:
    assert property ((r.ctrl_en && !r.ctrl_const && trig && !is_act) |=> is_act)
    else $error("operand trigger did not start test mode");

  a_flash_idle:
    assert property (!is_act ##1 !is_act |-> !test_indicator)
    else $error("indicator lit outside test mode");

  // forced values use the codes registered one cycle earlier
  a_input_open:
    assert property ((is_act && field2($past(r.in_force), 1) == tmcf_pkg::IN_FORCE_OPEN)
                     |-> !field_input_state[1])
    else $error("forced open input reports one");

  a_input_closed:
    assert property ((is_act && field2($past(r.in_force), 2) == tmcf_pkg::IN_FORCE_CLOSED)
                     |-> field_input_state[2])
    else $error("forced closed input reports zero");

  a_input_normal:
    assert property (!is_act |-> field_input_state == $past(r.filt[7:0]))
    else $error("input differs from sensed state outside test mode");

  a_output_normal:
    assert property (!is_act |-> field_output_drive == $past(out_command))
    else $error("output differs from command outside test mode");

  a_output_energ:
    assert property ((is_act && field2($past(r.out_force), 1) == tmcf_pkg::OUT_FORCE_ENERG)
                     |-> field_output_drive[1])
    else $error("energized output not closed");

  a_output_deenrg:
    assert property ((is_act && field2($past(r.out_force), 2) == tmcf_pkg::OUT_FORCE_DEENRG)
                     |-> !field_output_drive[2])
    else $error("de-energized output not open");

  a_freeze_entry:
    assert property ((s_enter ##0
                      (field2($past(r.out_force), 3) == tmcf_pkg::OUT_FORCE_FREEZE))
                     |-> field_output_drive[3] == $past(field_output_drive[3]))
    else $error("frozen output changed on entry");

  a_freeze_hold:
    assert property ((is_act && $past(is_act) && $stable(r.out_force)
                      && field2(r.out_force, 3) == tmcf_pkg::OUT_FORCE_FREEZE)
                     |-> $stable(field_output_drive[3]))
    else $error("frozen output moved during test mode");

endmodule

`default_nettype wire

// *** sim/tmcf_field.sv ***
// field contact circuits: input terminals and output detectors
`default_nettype none

module tmcf_field (
  input  wire logic [7:0] closed,
  input  wire logic [7:0] drive,
  output var  logic [7:0] pin,
  output var  logic [7:0] vdet,
  output var  logic [7:0] idet
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // terminals follow the bench, detectors follow the contacts
  // ----------------------------------------------------------------
  always_comb
  begin
    pin  = closed;
    vdet = drive;
    idet = drive;
  end
endmodule

`default_nettype wire

// *** sim/tmcf_top_test.sv ***
// self-checking bench of the test mode contact forcing block
`default_nettype none

module tmcf_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [7:0]  closed  = 8'h00;
  logic [7:0]  cmd     = 8'h00;
  logic [31:0] trig    = 32'h0;
  logic [31:0] rem_pt  = 32'h0;
  logic [31:0] rem_on  = 32'h0;
  logic [31:0] rem_def = 32'h0;
  logic [31:0] sin     = 32'h0;
  logic [63:0] sout    = 64'h0;
  logic [7:0]  pin, vdet, idet, fin_st, drv;
  logic        test_active, test_indicator, frz;
  logic [32:0] exp_q[$];
  int          seed = 37;
  int          n_fail = 0;
  int          compares = 0;
  int          cycles = 0;

  always #5 pclk = ~pclk;

  tmcf_top #(.FLASH_HALF_CYC(4)) i_tmcf_top (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .field_input_pin(pin), .volt_det_pin(vdet), .curr_det_pin(idet),
    .trig_operand(trig), .out_command(cmd), .remote_point(rem_pt),
    .remote_online(rem_on), .soft_input(sin), .soft_output(sout),
    .field_input_state(fin_st), .field_output_drive(drv), .test_active(test_active),
    .test_indicator(test_indicator)
  );

  tmcf_field i_tmcf_field (
    .closed(closed), .drive(drv), .pin(pin), .vdet(vdet), .idet(idet)
  );

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    begin
      compares++;
      if (seen !== exp)
      begin
        n_fail++;
        $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  task automatic report_and_stop;
    begin
      if (n_fail == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      report_and_stop;
    end
  end

  // read results taken off the queue as they appear
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      if (exp_q.size() == 0)
        n_fail++;
      else
        check($sformatf("read %h", paddr), {pslverr, prdata}, exp_q.pop_front());
    end

  // ----------------------------------------------------------------
  // apb master
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    begin
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      if (!wr)
        exp_q.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic wait_active(input logic v);
    int k;
    begin
      for (k = 0; k < 10 && test_active !== v; k++)
        @(posedge pclk);
      check("test active", {32'h0, test_active}, {32'h0, v});
    end
  endtask

  function automatic logic [32:0] ost(input logic [7:0] d);
    return {1'b0, 8'h00, d & tmcf_pkg::FORM_A_MASK, d & tmcf_pkg::FORM_A_MASK, d};
  endfunction

  function automatic logic [32:0] fin(input logic [7:0] p);
    return {25'h0, (p & 8'hF9) | 8'h04};
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    closed  <= 8'($random(seed));
    cmd     <= 8'($random(seed));
    rem_pt  <= $random(seed);
    rem_on  <= $random(seed);
    sin     <= $random(seed);
    sout    <= {32'($random(seed)), 32'($random(seed))};
    rd(tmcf_pkg::REG_CTRL, 33'h0_0000_0002);
    rd(8'h30, 33'h1_0000_0000);
    wr(tmcf_pkg::REG_IN_FORCE, 32'h0000_00E4);
    wr(tmcf_pkg::REG_OUT_FORCE, 32'h0000_00E4);
    rd(tmcf_pkg::REG_IN_FORCE, 33'h0_0000_00E4);
    rd(tmcf_pkg::REG_OUT_FORCE, 33'h0_0000_00E4);
    repeat (8) @(posedge pclk);
    rd(tmcf_pkg::REG_IN_STATE, {25'h0, closed});
    rd(tmcf_pkg::REG_OUT_STATE, ost(cmd));
    rd(tmcf_pkg::REG_STATUS, 33'h0);
    frz = cmd[3];
    wr(tmcf_pkg::REG_CTRL, 32'h0000_0003);
    wait_active(1'b1);
    @(posedge pclk);
    check("indicator", {32'h0, test_indicator}, 33'h1);
    repeat (4) @(posedge pclk);
    check("indicator", {32'h0, test_indicator}, 33'h0);
    rd(tmcf_pkg::REG_STATUS, 33'h1);
    rd(tmcf_pkg::REG_IN_STATE, fin(closed));
    cmd <= 8'($random(seed));
    repeat (8) @(posedge pclk);
    rd(tmcf_pkg::REG_OUT_STATE, ost((cmd & 8'hF1) | 8'h02 | {4'h0, frz, 3'h0}));
    closed <= 8'($random(seed));
    repeat (8) @(posedge pclk);
    rd(tmcf_pkg::REG_IN_STATE, fin(closed));
    wr(tmcf_pkg::REG_CTRL, 32'h0000_0002);
    wait_active(1'b0);
    repeat (8) @(posedge pclk);
    rd(tmcf_pkg::REG_OUT_STATE, ost(cmd));
    rd(tmcf_pkg::REG_IN_STATE, {25'h0, closed});
    check("indicator", {32'h0, test_indicator}, 33'h0);
    trig <= $random(seed) & 32'hFFFF_FFDF;
    wr(tmcf_pkg::REG_CTRL, 32'h0000_0501);
    repeat (3) @(posedge pclk);
    rd(tmcf_pkg::REG_STATUS, 33'h0);
    trig[5] <= 1'b1;
    wait_active(1'b1);
    trig[5] <= 1'b0;
    wait_active(1'b0);
    rem_def = $random(seed);
    wr(tmcf_pkg::REG_REM_DEF, rem_def);
    rd(tmcf_pkg::REG_REM_STATE, {1'b0, (rem_pt & rem_on) | (rem_def & ~rem_on)});
    rd(tmcf_pkg::REG_SOFT_IN, {1'b0, sin});
    rd(tmcf_pkg::REG_SOFT_OLO, {1'b0, sout[31:0]});
    rd(tmcf_pkg::REG_SOFT_OHI, {1'b0, sout[63:32]});
    report_and_stop;
  end
endmodule

`default_nettype wire
